// [pcamc_pkg.sv]
package pcamc_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_MODULES = 3;
    localparam int ADDR_W = 10;
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_MODE0 = 8'hDA;
    localparam logic [7:0] IDX_MODE1 = 8'hDB;
    localparam logic [7:0] IDX_MODE2 = 8'hDC;
    localparam logic [7:0] IDX_CNT_LOW = 8'hF9;
    localparam logic [7:0] IDX_CNT_HIGH = 8'hFA;
    localparam logic [7:0] IDX_PWM_CFG = 8'hF7;
    localparam logic [7:0] IDX_CMPL0 = 8'hFB;
    localparam logic [7:0] IDX_CMPL1 = 8'hE9;
    localparam logic [7:0] IDX_CMPL2 = 8'hEB;
    localparam logic [7:0] IDX_CMPH0 = 8'hFC;
    localparam logic [7:0] IDX_CMPH1 = 8'hEA;
    localparam logic [7:0] IDX_CMPH2 = 8'hEC;
    localparam logic [7:0] IDX_ARRAY_MODE = 8'hD9;
    localparam logic [7:0] IDX_STATUS = 8'hE0;
    localparam logic [7:0] IDX_CLEAR = 8'hE1;
    localparam logic [7:0] IDX_IRQ_EN = 8'hE2;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MB_WIDE = 7;
    localparam int MB_CMP = 6;
    localparam int MB_RISE = 5;
    localparam int MB_FALL = 4;
    localparam int MB_MATCH = 3;
    localparam int MB_TOG = 2;
    localparam int MB_PWM = 1;
    localparam int MB_IRQ = 0;
    localparam int AM_RUN = 0;
    localparam int AM_WDOG = 6;
    localparam int ST_OVF = 3;
    localparam int CLSEL_LSB = 0;

    // ------------------------------------------------------------
    // reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] CLSEL_RST = 2'h0;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] PWM_BASE_BITS = 8'h08;

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [SYNC_STAGES-1:0] sync;
        logic level;
        logic pinOut;
        logic [7:0] freqAcc;
    } pcamc_chan_s;

    typedef struct packed {
        logic [NUM_MODULES-1:0][7:0] mode;
        logic [NUM_MODULES-1:0][15:0] cmp;
        logic [15:0] cnt;
        logic [7:0] snapHi;
        logic step;
        logic [1:0] clsel;
        logic run;
        logic wdog;
        logic wdogExpire;
        logic [3:0] flags;
        logic ovfIrqEn;
        logic awHeld;
        logic [7:0] awIdx;
        logic wHeld;
        logic [7:0] wData;
        logic wLane0;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [7:0] rData;
        logic [1:0] rResp;
    } pcamc_top_s;

endpackage : pcamc_pkg

// [pcamc_chan.sv]
`timescale 1ns/1ns
module pcamc_chan (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [7:0] modeBits,
    input wire logic [15:0] counter,
    input wire logic cntStep,
    input wire logic [15:0] cmpValue,
    input wire logic [1:0] cycleSel,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    output logic captureHit,
    output logic matchHit
);
    import pcamc_pkg::*;

    pcamc_chan_s s_r;
    pcamc_chan_s s_nxt;
    logic [7:0] pwmBits;
    logic [15:0] pwmMask;
    logic pwmLevel;
    logic edgeSeen;

    // ------------------------------------------------------------
    // pin edges, compare and waveform
    // ------------------------------------------------------------
    assign pwmBits = PWM_BASE_BITS + {6'h00, cycleSel};
    assign pwmMask = 16'((17'h00001 << pwmBits) - 17'h00001);
    assign pwmLevel = modeBits[MB_WIDE] ? (counter >= cmpValue)
        : ((counter & pwmMask) >= (cmpValue & pwmMask));
    assign edgeSeen = (s_r.sync[1] == s_r.sync[2])
        && (s_r.sync[2] != s_r.level);
    assign captureHit = edgeSeen
        && ((s_r.sync[2] && modeBits[MB_RISE])
        || (!s_r.sync[2] && modeBits[MB_FALL]));
    assign matchHit = modeBits[MB_CMP] && cntStep
        && (counter == cmpValue);
    assign pinOut = s_r.pinOut;
    assign pinOe = modeBits[MB_TOG] | modeBits[MB_PWM];

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync = {s_r.sync[1:0], pinIn};
        if (s_r.sync[1] == s_r.sync[2]) begin
            s_nxt.level = s_r.sync[2];
        end
        if (modeBits[MB_TOG] && modeBits[MB_PWM]) begin
            // frequency output: toggle, then step the match point
            if (cntStep && counter[7:0] == s_r.freqAcc) begin
                s_nxt.pinOut = !s_r.pinOut;
                s_nxt.freqAcc = s_r.freqAcc + cmpValue[15:8];
            end
        end else if (modeBits[MB_PWM]) begin
            s_nxt.pinOut = pwmLevel;
        end else if (modeBits[MB_TOG] && matchHit) begin
            s_nxt.pinOut = !s_r.pinOut;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : pcamc_chan

// [pcamc_top.sv]
// What this block does
// - mode bit 7 picks 16-bit PWM when set, else 8 to 11-bit PWM.
// - mode bit 6 enables the module comparator against the main counter.
// - mode bit 5 enables capture on rising input pin edges.
// - mode bit 4 enables capture on falling edges; both may be on.
// - mode bit 3 sets the module flag when counter equals compare value.
// - mode bit 2 inverts the output pin on each counter match.
// - toggle and PWM both set give frequency output mode.
// - mode bit 1 drives PWM on the output pin at selected width.
// - mode bit 0 lets a set module flag raise an interrupt.
// - watchdog enable locks module 2 mode; software disables first.
// - watchdog enable makes counter byte writes be ignored.
// - counter low and high bytes at adjacent addresses, reset zero.
// - high byte reads a snapshot loaded only when low byte is read.
// - three 8-bit mode registers at own addresses, reset zero.
// - shared two-bit field picks 8, 9, 10 or 11-bit PWM cycle.
// - compare low byte write clears the comparator enable bit.
// - compare high byte write sets the comparator enable bit.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
module pcamc_top (
    input wire logic ref_clk,
    input wire logic reset_n,
    // AXI4-Lite slave
    input wire logic [pcamc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pcamc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // module pins
    input wire logic [pcamc_pkg::NUM_MODULES-1:0] moduleIoPinIn,
    output logic [pcamc_pkg::NUM_MODULES-1:0] moduleIoPinOut,
    output logic [pcamc_pkg::NUM_MODULES-1:0] moduleIoPinOe,
    // events
    output logic irq,
    output logic watchdogExpire
);
    import pcamc_pkg::*;

    pcamc_top_s s_r;
    pcamc_top_s s_nxt;
    logic [NUM_MODULES-1:0] captureHit;
    logic [NUM_MODULES-1:0] matchHit;
    logic [NUM_MODULES-1:0][7:0] chanMode;
    logic [NUM_MODULES-1:0] irqMask;
    logic awTake;
    logic wTake;
    logic arTake;
    logic [15:0] ovfMask;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic [7:0] idxOf(
        input logic [ADDR_W-1:0] addr
    );
        idxOf = addr[9:2];
    endfunction : idxOf

    function automatic logic isMapped(input logic [7:0] idx);
        unique case (idx)
            IDX_MODE0, IDX_MODE1, IDX_MODE2, IDX_CNT_LOW, IDX_CNT_HIGH,
            IDX_PWM_CFG, IDX_CMPL0, IDX_CMPL1, IDX_CMPL2, IDX_CMPH0,
            IDX_CMPH1, IDX_CMPH2, IDX_ARRAY_MODE, IDX_STATUS, IDX_CLEAR,
            IDX_IRQ_EN: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction : isMapped

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    generate
        for (genvar n = 0; n < NUM_MODULES; n++) begin : g_chan
            // module 2 serves only as the watchdog while it is armed
            assign chanMode[n] = (n == 2 && s_r.wdog) ? MODE_RST
                : s_r.mode[n];
            assign irqMask[n] = s_r.mode[n][MB_IRQ];
            pcamc_chan u_chan (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .modeBits(chanMode[n]),
                .counter(s_r.cnt),
                .cntStep(s_r.step),
                .cmpValue(s_r.cmp[n]),
                .cycleSel(s_r.clsel),
                .pinIn(moduleIoPinIn[n]),
                .pinOut(moduleIoPinOut[n]),
                .pinOe(moduleIoPinOe[n]),
                .captureHit(captureHit[n]),
                .matchHit(matchHit[n])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // bus handshakes and outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !s_r.awHeld && !s_r.bValid;
    assign s_axi_wready = !s_r.wHeld && !s_r.bValid;
    assign s_axi_arready = !s_r.rValid;
    assign awTake = s_axi_awvalid && s_axi_awready;
    assign wTake = s_axi_wvalid && s_axi_wready;
    assign arTake = s_axi_arvalid && s_axi_arready;
    assign s_axi_bvalid = s_r.bValid;
    assign s_axi_bresp = s_r.bResp;
    assign s_axi_rvalid = s_r.rValid;
    assign s_axi_rresp = s_r.rResp;
    assign s_axi_rdata = {24'h000000, s_r.rData};
    assign irq = (|(s_r.flags[NUM_MODULES-1:0] & irqMask))
        || (s_r.flags[ST_OVF] && s_r.ovfIrqEn);
    assign watchdogExpire = s_r.wdogExpire;
    assign ovfMask = 16'((17'h00001 << (PWM_BASE_BITS
        + {6'h00, s_r.clsel})) - 17'h00001);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] wd;
        logic doWrite;
        logic [3:0] setFlags;
        logic [3:0] clrFlags;
        wd = s_r.wData;
        doWrite = s_r.awHeld && s_r.wHeld && !s_r.bValid;
        setFlags = 4'h0;
        clrFlags = 4'h0;
        s_nxt = s_r;
        s_nxt.wdogExpire = 1'b0;

        // counter runs one count per clock while enabled
        s_nxt.step = s_r.run;
        if (s_r.run) begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
        if (s_r.step && (s_r.cnt & ovfMask) == CNT_RST) begin
            setFlags[ST_OVF] = 1'b1;
        end
        if (s_r.wdog && s_r.step && s_r.cnt == s_r.cmp[2]) begin
            s_nxt.wdogExpire = 1'b1;
        end

        // write channel
        if (awTake) begin
            s_nxt.awHeld = 1'b1;
            s_nxt.awIdx = idxOf(s_axi_awaddr);
        end
        if (wTake) begin
            s_nxt.wHeld = 1'b1;
            s_nxt.wData = s_axi_wdata[7:0];
            s_nxt.wLane0 = s_axi_wstrb[0];
        end
        if (doWrite) begin
            s_nxt.awHeld = 1'b0;
            s_nxt.wHeld = 1'b0;
            s_nxt.bValid = 1'b1;
            s_nxt.bResp = isMapped(s_r.awIdx) ? RESP_OKAY : RESP_SLVERR;
        end
        if (doWrite && s_r.wLane0) begin
            unique case (s_r.awIdx)
                IDX_MODE0: s_nxt.mode[0] = wd;
                IDX_MODE1: s_nxt.mode[1] = wd;
                IDX_MODE2: begin
                    if (!s_r.wdog) begin
                        s_nxt.mode[2] = wd;
                    end
                end
                IDX_CNT_LOW: begin
                    if (!s_r.wdog) begin
                        s_nxt.cnt[7:0] = wd;
                    end
                end
                IDX_CNT_HIGH: begin
                    if (!s_r.wdog) begin
                        s_nxt.cnt[15:8] = wd;
                    end
                end
                IDX_PWM_CFG: s_nxt.clsel = wd[CLSEL_LSB+:2];
                IDX_CMPL0: begin
                    s_nxt.cmp[0][7:0] = wd;
                    s_nxt.mode[0][MB_CMP] = 1'b0;
                end
                IDX_CMPL1: begin
                    s_nxt.cmp[1][7:0] = wd;
                    s_nxt.mode[1][MB_CMP] = 1'b0;
                end
                IDX_CMPL2: begin
                    s_nxt.cmp[2][7:0] = wd;
                    if (!s_r.wdog) begin
                        s_nxt.mode[2][MB_CMP] = 1'b0;
                    end
                end
                IDX_CMPH0: begin
                    s_nxt.cmp[0][15:8] = wd;
                    s_nxt.mode[0][MB_CMP] = 1'b1;
                end
                IDX_CMPH1: begin
                    s_nxt.cmp[1][15:8] = wd;
                    s_nxt.mode[1][MB_CMP] = 1'b1;
                end
                IDX_CMPH2: begin
                    s_nxt.cmp[2][15:8] = wd;
                    if (!s_r.wdog) begin
                        s_nxt.mode[2][MB_CMP] = 1'b1;
                    end
                end
                IDX_ARRAY_MODE: begin
                    // while armed only the watchdog bit itself may change
                    s_nxt.wdog = wd[AM_WDOG];
                    if (!s_r.wdog) begin
                        s_nxt.run = wd[AM_RUN];
                    end
                end
                IDX_CLEAR: clrFlags = wd[3:0];
                IDX_IRQ_EN: begin
                    s_nxt.mode[0][MB_IRQ] = wd[0];
                    s_nxt.mode[1][MB_IRQ] = wd[1];
                    if (!s_r.wdog) begin
                        s_nxt.mode[2][MB_IRQ] = wd[2];
                    end
                    s_nxt.ovfIrqEn = wd[ST_OVF];
                end
                default: begin
                end
            endcase
        end
        if (s_r.bValid && s_axi_bready) begin
            s_nxt.bValid = 1'b0;
        end

        // read channel
        if (s_r.rValid && s_axi_rready) begin
            s_nxt.rValid = 1'b0;
        end
        if (arTake) begin
            s_nxt.rValid = 1'b1;
            s_nxt.rResp = isMapped(idxOf(s_axi_araddr)) ? RESP_OKAY
                : RESP_SLVERR;
            unique case (idxOf(s_axi_araddr))
                IDX_MODE0: s_nxt.rData = s_r.mode[0];
                IDX_MODE1: s_nxt.rData = s_r.mode[1];
                IDX_MODE2: s_nxt.rData = s_r.mode[2];
                IDX_CNT_LOW: begin
                    s_nxt.rData = s_r.cnt[7:0];
                    s_nxt.snapHi = s_r.cnt[15:8];
                end
                IDX_CNT_HIGH: s_nxt.rData = s_r.snapHi;
                IDX_PWM_CFG: s_nxt.rData = {6'h00, s_r.clsel};
                IDX_CMPL0: s_nxt.rData = s_r.cmp[0][7:0];
                IDX_CMPL1: s_nxt.rData = s_r.cmp[1][7:0];
                IDX_CMPL2: s_nxt.rData = s_r.cmp[2][7:0];
                IDX_CMPH0: s_nxt.rData = s_r.cmp[0][15:8];
                IDX_CMPH1: s_nxt.rData = s_r.cmp[1][15:8];
                IDX_CMPH2: s_nxt.rData = s_r.cmp[2][15:8];
                IDX_ARRAY_MODE: begin
                    s_nxt.rData = BYTE_RST;
                    s_nxt.rData[AM_WDOG] = s_r.wdog;
                    s_nxt.rData[AM_RUN] = s_r.run;
                end
                IDX_STATUS: s_nxt.rData = {4'h0, s_r.flags};
                IDX_IRQ_EN: s_nxt.rData = {4'h0, s_r.ovfIrqEn,
                    irqMask};
                default: s_nxt.rData = BYTE_RST;
            endcase
        end

        // hardware events on the modules
        for (int n = 0; n < NUM_MODULES; n++) begin
            if (matchHit[n] && chanMode[n][MB_MATCH]) begin
                setFlags[n] = 1'b1;
            end
            if (captureHit[n]) begin
                s_nxt.cmp[n] = s_r.cnt;
                setFlags[n] = 1'b1;
            end
        end
        // a flag set in the same cycle as its clear stays set
        s_nxt.flags = (s_r.flags & ~clrFlags) | setFlags;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : pcamc_top

// [pcamc_pin_model.sv]
`timescale 1ns/1ns
module pcamc_pin_model
    import pcamc_pkg::*;
(
    input wire logic [pcamc_pkg::NUM_MODULES-1:0] pinOut,
    input wire logic [pcamc_pkg::NUM_MODULES-1:0] pinOe,
    output logic [pcamc_pkg::NUM_MODULES-1:0] pinIn
);
    logic [NUM_MODULES-1:0] extLevel = '0;

    // ------------------------------------------------------------
    // wire level: module drive wins, else the external source
    // ------------------------------------------------------------
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);

    task automatic drive(input int ch, input logic v);
        extLevel[ch] <= v;
    endtask : drive
endmodule : pcamc_pin_model

// [pcamc_top_sva.sv]
`timescale 1ns/1ns
module pcamc_top_sva
    import pcamc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [pcamc_pkg::NUM_MODULES-1:0] moduleIoPinOe,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    AST_AW_BLOCKED: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write ready in resp");
    AST_AR_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready high with rvalid");
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response latency");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read response latency");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("bvalid after handshake");
    AST_RDATA_BYTE: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data above bit 7");
    AST_RESET_IDLE: assert property ($rose(reset_n) |-> !irq &&
        moduleIoPinOe == '0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not idle after reset");
endmodule : pcamc_top_sva

bind pcamc_top pcamc_top_sva sva (.ref_clk(ref_clk), .reset_n(reset_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .moduleIoPinOe(moduleIoPinOe), .irq(irq));

// [pcamc_tb.sv]
`timescale 1ns/1ns
module tb;
    import pcamc_pkg::*;
    logic ref_clk, reset_n;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, irq, watchdogExpire;
    logic [2:0] pinIn, pinOut, pinOe;
    int fails, n_tests, hi, tg, wdx;

    pcamc_top uut (.ref_clk(ref_clk), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .moduleIoPinIn(pinIn),
        .moduleIoPinOut(pinOut), .moduleIoPinOe(pinOe), .irq(irq),
        .watchdogExpire(watchdogExpire));
    pcamc_pin_model pm (.pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));
    always @(posedge ref_clk) if (watchdogExpire === 1'b1) wdx++;

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(negedge ref_clk); while (!(s_axi_awready && s_axi_wready));
        @(posedge ref_clk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(negedge ref_clk); while (!s_axi_bvalid);
        @(posedge ref_clk) s_axi_bready <= 1'b1;
        @(posedge ref_clk) resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] idx);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        do @(negedge ref_clk); while (!s_axi_arready);
        @(posedge ref_clk) s_axi_arvalid <= 1'b0;
        do @(negedge ref_clk); while (!s_axi_rvalid);
        @(posedge ref_clk) s_axi_rready <= 1'b1;
        @(posedge ref_clk);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rdr

    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        rdr(idx);
        chk(rd, {24'h000000, exp});
    endtask : rc

    // high cycles and level changes of one pin over n cycles
    task automatic cnt_pin(input int ch, input int n);
        logic p;
        hi = 0;
        tg = 0;
        p = pinOut[ch];
        repeat (n) begin
            @(posedge ref_clk);
            if (pinOut[ch] === 1'b1) hi++;
            if (pinOut[ch] !== p) tg++;
            p = pinOut[ch];
        end
    endtask : cnt_pin

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wait_cyc

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    initial begin
        wait_cyc(60000);
        fails++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        wait_cyc(16);
        reset_n <= 1'b1;
        wait_cyc(1);
        rc(IDX_MODE0, 8'h00);
        rc(IDX_MODE1, 8'h00);
        rc(IDX_MODE2, 8'h00);
        rc(IDX_CNT_LOW, 8'h00);
        rc(IDX_CNT_HIGH, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(IDX_MODE0 + 8'(i), 8'hA5 ^ 8'(i));
            rc(IDX_MODE0 + 8'(i), 8'hA5 ^ 8'(i));
            wr(IDX_MODE0 + 8'(i), 8'h00);
        end
        chk(resp, RESP_OKAY);
        wr(8'h00, 8'h01);
        chk(resp, RESP_SLVERR);
        rdr(8'h00);
        chk(resp, RESP_SLVERR);
        $display("test reset and access done");
        wr(IDX_CMPH0, 8'h00);
        rc(IDX_MODE0, 8'h40);
        wr(IDX_CMPL0, 8'h40);
        rc(IDX_MODE0, 8'h00);
        wr(IDX_CNT_LOW, 8'h34);
        wr(IDX_CNT_HIGH, 8'h12);
        rc(IDX_CNT_LOW, 8'h34);
        rc(IDX_CNT_HIGH, 8'h12);
        wr(IDX_CNT_HIGH, 8'h56);
        rc(IDX_CNT_HIGH, 8'h12);
        rc(IDX_CNT_LOW, 8'h34);
        rc(IDX_CNT_HIGH, 8'h56);
        $display("test compare enable and counter done");
        wr(IDX_CMPH0, 8'h00);
        wr(IDX_CLEAR, 8'h0F);
        wr(IDX_MODE0, 8'h49);
        wr(IDX_CMPL1, 8'h20);
        wr(IDX_CMPH1, 8'h00);
        wr(IDX_MODE1, 8'h44);
        wr(IDX_CNT_LOW, 8'h00);
        wr(IDX_CNT_HIGH, 8'h00);
        wr(IDX_ARRAY_MODE, 8'h01);
        wait_cyc(100);
        chk(irq, 1'b1);
        chk(pinOut[1], 1'b1);
        chk(pinOe[1], 1'b1);
        rc(IDX_STATUS, 8'h01);
        wr(IDX_CLEAR, 8'h01);
        chk(irq, 1'b0);
        wr(IDX_MODE0, 8'h48);
        wr(IDX_ARRAY_MODE, 8'h00);
        wr(IDX_CNT_LOW, 8'h30);
        wr(IDX_ARRAY_MODE, 8'h01);
        wait_cyc(40);
        rc(IDX_STATUS, 8'h01);
        chk(irq, 1'b0);
        wr(IDX_CLEAR, 8'h0F);
        wr(IDX_MODE1, 8'h00);
        $display("test match toggle irq done");
        wr(IDX_CMPL0, 8'h80);
        wr(IDX_CMPH0, 8'h00);
        wr(IDX_MODE0, 8'h42);
        for (int c = 0; c < 4; c++) begin
            wr(IDX_PWM_CFG, 8'(c));
            wait_cyc(20);
            cnt_pin(0, 256 << c);
            chk(hi, (256 << c) - 128);
        end
        chk(pinOe[0], 1'b1);
        wr(IDX_PWM_CFG, 8'h00);
        wr(IDX_ARRAY_MODE, 8'h00);
        wr(IDX_CNT_LOW, 8'h00);
        wr(IDX_CNT_HIGH, 8'h01);
        wr(IDX_MODE0, 8'hC2);
        wr(IDX_ARRAY_MODE, 8'h01);
        cnt_pin(0, 200);
        chk(hi, 200);
        wr(IDX_CMPH0, 8'h10);
        wr(IDX_MODE0, 8'h46);
        wait_cyc(64);
        cnt_pin(0, 256);
        chk(tg, 16);
        wr(IDX_ARRAY_MODE, 8'h00);
        wr(IDX_MODE0, 8'h00);
        $display("test pwm and frequency done");
        wr(IDX_CNT_LOW, 8'h34);
        wr(IDX_CNT_HIGH, 8'h12);
        wr(IDX_MODE2, 8'h20);
        wr(IDX_CLEAR, 8'h0F);
        pm.drive(2, 1'b1);
        wait_cyc(20);
        rc(IDX_STATUS, 8'h04);
        rc(IDX_CMPL2, 8'h34);
        rc(IDX_CMPH2, 8'h12);
        wr(IDX_CLEAR, 8'h04);
        pm.drive(2, 1'b0);
        wait_cyc(20);
        rc(IDX_STATUS, 8'h00);
        wr(IDX_MODE2, 8'h10);
        pm.drive(2, 1'b1);
        wait_cyc(20);
        rc(IDX_STATUS, 8'h00);
        pm.drive(2, 1'b0);
        wait_cyc(20);
        rc(IDX_STATUS, 8'h04);
        $display("test capture done");
        wr(IDX_CNT_LOW, 8'h07);
        wr(IDX_ARRAY_MODE, 8'h40);
        wr(IDX_MODE2, 8'hFF);
        rc(IDX_MODE2, 8'h10);
        wr(IDX_CNT_LOW, 8'h55);
        wr(IDX_CNT_HIGH, 8'h55);
        rc(IDX_CNT_LOW, 8'h07);
        rc(IDX_CNT_HIGH, 8'h12);
        wr(IDX_ARRAY_MODE, 8'h00);
        wr(IDX_MODE2, 8'h00);
        rc(IDX_MODE2, 8'h00);
        wr(IDX_CNT_LOW, 8'h30);
        wr(IDX_ARRAY_MODE, 8'h41);
        wait_cyc(20);
        chk(wdx, 1);
        $display("test watchdog lock done");
        tally_and_finish();
    end
endmodule : tb
